/* File: logic/mseq_pkg.sv */
package mseq_pkg;
  // ****************************************************
  // sequencer constants
  // ****************************************************
  localparam int PC_W = 6;
  localparam int MW_W = 22;
  localparam logic [5:0] PC_IDLE = 6'h00;
  localparam logic [5:0] PC_BREAK = 6'h3f;
  localparam logic [1:0] SRC_T = 2'h0;
  localparam logic [1:0] SRC_DA = 2'h1;
  localparam logic [1:0] SRC_RS = 2'h2;
  localparam logic [1:0] SRC_SAR = 2'h3;
  localparam logic [3:0] CODE_CONT = 4'h2;
  // microword bit positions, bit n-1 holds P<n>
  localparam int CSA_LO = 0;
  localparam int CSB_LO = 4;
  localparam int COND_LO = 8;
  localparam int LC1_LO = 14;
  localparam int LC2_HI = 17;
  localparam int LC2_LO = 18;
  localparam int LC3_LO = 19;
  localparam int ALT_BIT = 21;
  localparam logic [2:0] LC1_NOP = 3'h0;
  localparam logic [2:0] LC1_DEC = 3'h1;
  localparam logic [2:0] LC1_LD = 3'h2;
  localparam logic [2:0] LC1_LDA = 3'h3;
  localparam logic [2:0] LC1_ZDEC2 = 3'h4;
  localparam logic [2:0] LC1_ZALT13 = 3'h5;
  localparam logic [2:0] LC1_ZLD = 3'h6;
  localparam logic [2:0] LC1_ZLDA = 3'h7;
  localparam logic [1:0] LC3_NOP = 2'h0;
  localparam logic [1:0] LC3_DEC = 2'h1;
  localparam logic [1:0] LC3_LD = 2'h2;
  localparam logic [1:0] LC3_ZLD = 2'h3;
  // ****************************************************
  // register map
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_RELOAD1 = 8'h08;
  localparam logic [7:0] REG_RELOAD2 = 8'h0c;
  localparam logic [7:0] REG_RELOAD3 = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_COUNT12 = 8'h18;
  localparam logic [7:0] REG_COUNT3 = 8'h1c;
  localparam int CTRL_LAUNCH = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_IRQ_SET = 2;
  localparam int CTRL_IRQ_CLR = 3;
  localparam int CTRL_READY = 4;
  localparam int CTRL_LAUNCH_EN = 5;
  localparam int ST_PC_LO = 0;
  localparam int ST_RUN = 8;
  localparam int ST_IRQ = 9;
  localparam int ST_READY = 10;
  localparam int ST_PHASE = 11;
  localparam int HI_LO = 16;
  typedef enum logic [1:0] {IRQ_NONE, IRQ_CONT, IRQ_PUSH, IRQ_HOLD}
    mseq_irq_t;
endpackage : mseq_pkg

/* File: logic/mseq_top.sv */
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module mseq_top #(
  parameter int CNT_W = 12,
  parameter int STACK_D = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [5:0] pc,
  input wire logic [21:0] mw_word,
  input wire logic [5:0] direct_jump_field,
  output logic run
);
  // ****************************************************
  // checks and state
  // ****************************************************
  if (CNT_W < 2 || CNT_W > 16)
    $error("mseq_top: CNT_W must be 2 to 16");
  if (STACK_D < 2)
    $error("mseq_top: STACK_D must be at least 2");

  logic phase;
  logic [5:0] tnext, start_address_register, next_pc;
  logic [5:0] return_stack [STACK_D];
  logic [CNT_W-1:0] loop_count_one, loop_count_two, loop_count_three;
  logic [CNT_W-1:0] loop_reload_one, loop_reload_two, loop_reload_three;
  logic [CNT_W-1:0] loop_reload_alt;
  logic [CNT_W-1:0] next_lc1, next_lc2, next_lc3;
  logic irq, ready, launch_en, launch_req, clear_req;
  mseq_pkg::mseq_irq_t irq_st;
  logic step, clear_go, launch_go, z1, z2, z3;
  logic [3:0] code;
  logic pc_source_hi, pc_source_lo, file_enable_n, push_pop_select;
  logic do_push, do_pop, dec2;
  logic [5:0] push_val;
  logic ap_wr;
  logic [7:0] ap_addr;

  function automatic logic busy(input logic [5:0] p);
    busy = p != mseq_pkg::PC_IDLE && p != mseq_pkg::PC_BREAK;
  endfunction : busy

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    dec = v - {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction : dec

  function automatic logic [CNT_W-1:0] wfield(input logic [31:0] d);
    wfield = d[CNT_W-1:0];
  endfunction : wfield

  assign step = ce & phase;
  assign clear_go = clear_req;
  assign z1 = loop_count_one == '0;
  assign z2 = loop_count_two == '0;
  assign z3 = loop_count_three == '0;
  assign launch_go = step & launch_req & launch_en & ready & !run
    & !clear_go & irq_st == mseq_pkg::IRQ_NONE;

  // ****************************************************
  // condition test unit
  // ****************************************************
  always_comb
  begin
    logic [5:0] c;
    logic [3:0] ca, cb;
    logic t1, t2;
    t1 = 1'b0;
    t2 = 1'b0;
    c = mw_word[mseq_pkg::COND_LO +: 6];
    ca = mw_word[mseq_pkg::CSA_LO +: 4];
    cb = mw_word[mseq_pkg::CSB_LO +: 4];
    if (c[5])
    begin
      // upper bits low invert counter two / three
      t1 = (c[0] & z1) | (c[1] & (z2 ^ !c[3]))
        | (c[2] & (z3 ^ !c[4]));
      code = t1 ? cb : ca;
    end
    else
    begin
      t1 = (c[0] & (z1 ^ !c[4])) | (c[2] & (z3 ^ !c[4]));
      t2 = c[1] & (z2 ^ !c[3]);
      code = t1 ? cb : t2 ? ca : mseq_pkg::CODE_CONT;
    end
    if (irq_st == mseq_pkg::IRQ_CONT)
      code = mseq_pkg::CODE_CONT;
  end

  assign {pc_source_hi, pc_source_lo, file_enable_n, push_pop_select} = code;

  // ****************************************************
  // next address selection
  // ****************************************************
  always_comb
  begin
    do_push = !file_enable_n & push_pop_select;
    do_pop = !file_enable_n & !push_pop_select;
    push_val = tnext;
    case ({pc_source_hi, pc_source_lo})
      mseq_pkg::SRC_T: next_pc = tnext;
      mseq_pkg::SRC_DA: next_pc = direct_jump_field;
      mseq_pkg::SRC_RS: next_pc = return_stack[0];
      mseq_pkg::SRC_SAR: next_pc = start_address_register;
      default: next_pc = tnext;
    endcase
    if (launch_go)
    begin
      next_pc = start_address_register;
      do_push = 1'b0;
      do_pop = 1'b0;
    end
    else if (irq_st == mseq_pkg::IRQ_PUSH)
    begin
      next_pc = mseq_pkg::PC_BREAK;
      push_val = pc;
      do_push = 1'b1;
      do_pop = 1'b0;
    end
    else if (irq_st == mseq_pkg::IRQ_HOLD && !irq)
    begin
      next_pc = return_stack[0];
      do_push = 1'b0;
      do_pop = 1'b1;
    end
  end

  // pc update; incrementer held off at idle location
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pc <= mseq_pkg::PC_IDLE;
      tnext <= mseq_pkg::PC_IDLE;
      run <= 1'b0;
    end
    else if (ce)
    begin
      if (clear_go)
      begin
        pc <= mseq_pkg::PC_IDLE;
        tnext <= mseq_pkg::PC_IDLE;
        run <= 1'b0;
      end
      else if (step)
      begin
        pc <= next_pc;
        tnext <= next_pc == mseq_pkg::PC_IDLE ? mseq_pkg::PC_IDLE
          : next_pc + 6'h01;
        run <= busy(next_pc);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      phase <= 1'b0;
    else if (ce)
      phase <= clear_go ? 1'b0 : !phase;
  end

  // break-point sequencer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      irq_st <= mseq_pkg::IRQ_NONE;
    else if (ce)
    begin
      if (clear_go)
        irq_st <= mseq_pkg::IRQ_NONE;
      else if (step)
        case (irq_st)
          mseq_pkg::IRQ_NONE:
            if (irq && !launch_go)
              irq_st <= mseq_pkg::IRQ_CONT;
          mseq_pkg::IRQ_CONT: irq_st <= mseq_pkg::IRQ_PUSH;
          mseq_pkg::IRQ_PUSH: irq_st <= mseq_pkg::IRQ_HOLD;
          mseq_pkg::IRQ_HOLD:
            if (!irq)
              irq_st <= mseq_pkg::IRQ_NONE;
          default: irq_st <= mseq_pkg::IRQ_NONE;
        endcase
    end
  end

  // ****************************************************
  // return stack, left without reset on purpose
  // ****************************************************
  for (genvar i = 0; i < STACK_D; i++)
  begin : g_stk
    always_ff @(posedge clk_sys)
    begin
      if (step && !clear_go)
      begin
        if (do_push)
          return_stack[i] <= i == 0 ? push_val
            : return_stack[(i + STACK_D - 1) % STACK_D];
        else if (do_pop)
          return_stack[i] <= return_stack[(i + 1) % STACK_D];
      end
    end
  end

  // ****************************************************
  // loop counters
  // ****************************************************
  always_comb
  begin
    logic [1:0] op2;
    op2 = 2'h0;
    dec2 = 1'b0;
    next_lc1 = loop_count_one;
    case (mw_word[mseq_pkg::LC1_LO +: 3])
      mseq_pkg::LC1_NOP: next_lc1 = loop_count_one;
      mseq_pkg::LC1_DEC: next_lc1 = dec(loop_count_one);
      mseq_pkg::LC1_LD: next_lc1 = loop_reload_one;
      mseq_pkg::LC1_LDA: next_lc1 = loop_reload_alt;
      mseq_pkg::LC1_ZDEC2:
      begin
        next_lc1 = z1 ? loop_reload_one : dec(loop_count_one);
        dec2 = z1;
      end
      mseq_pkg::LC1_ZALT13:
        next_lc1 = z1 | z3 ? loop_reload_alt : dec(loop_count_one);
      mseq_pkg::LC1_ZLD:
        next_lc1 = z1 ? loop_reload_one : dec(loop_count_one);
      mseq_pkg::LC1_ZLDA:
        next_lc1 = z1 ? loop_reload_alt : dec(loop_count_one);
      default: next_lc1 = loop_count_one;
    endcase
    op2 = {mw_word[mseq_pkg::LC2_HI], mw_word[mseq_pkg::LC2_LO]};
    // reload beats the chained decrement from counter one
    next_lc2 = op2[1] ? loop_reload_two
      : op2[0] | dec2 ? dec(loop_count_two) : loop_count_two;
    case (mw_word[mseq_pkg::LC3_LO +: 2])
      mseq_pkg::LC3_NOP: next_lc3 = loop_count_three;
      mseq_pkg::LC3_DEC: next_lc3 = dec(loop_count_three);
      mseq_pkg::LC3_LD: next_lc3 = loop_reload_three;
      mseq_pkg::LC3_ZLD:
        next_lc3 = z3 ? loop_reload_three : dec(loop_count_three);
      default: next_lc3 = loop_count_three;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      loop_count_one <= '0;
      loop_count_two <= '0;
      loop_count_three <= '0;
    end
    else if (ce && clear_go)
    begin
      loop_count_one <= '0;
      loop_count_two <= '0;
      loop_count_three <= '0;
    end
    else if (step)
    begin
      loop_count_one <= next_lc1;
      loop_count_two <= next_lc2;
      loop_count_three <= next_lc3;
    end
  end

  // middle of the cycle, so counter one is not yet updated
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      loop_reload_alt <= '0;
    else if (ce && !phase && !clear_go && mw_word[mseq_pkg::ALT_BIT])
      loop_reload_alt <= loop_count_one;
  end

  // ****************************************************
  // bus slave, zero wait, stays live while ce is low
  // ****************************************************
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ap_wr <= 1'b0;
      ap_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (hsel && htrans[1] && hready)
    begin
      ap_wr <= hwrite;
      ap_addr <= haddr[mseq_pkg::ADDR_W-1:0];
      hrdata <= '0;
      if (!hwrite)
        case (haddr[mseq_pkg::ADDR_W-1:0])
          mseq_pkg::REG_CTRL: hrdata[mseq_pkg::CTRL_LAUNCH_EN] <= launch_en;
          mseq_pkg::REG_START: hrdata[5:0] <= start_address_register;
          mseq_pkg::REG_RELOAD1: hrdata[CNT_W-1:0] <= loop_reload_one;
          mseq_pkg::REG_RELOAD2: hrdata[CNT_W-1:0] <= loop_reload_two;
          mseq_pkg::REG_RELOAD3: hrdata[CNT_W-1:0] <= loop_reload_three;
          mseq_pkg::REG_STATUS:
          begin
            hrdata[mseq_pkg::ST_PC_LO +: 6] <= pc;
            hrdata[mseq_pkg::ST_RUN] <= run;
            hrdata[mseq_pkg::ST_IRQ] <= irq;
            hrdata[mseq_pkg::ST_READY] <= ready;
            hrdata[mseq_pkg::ST_PHASE] <= phase;
          end
          mseq_pkg::REG_COUNT12:
          begin
            hrdata[CNT_W-1:0] <= loop_count_one;
            hrdata[mseq_pkg::HI_LO +: CNT_W] <= loop_count_two;
          end
          mseq_pkg::REG_COUNT3:
          begin
            hrdata[CNT_W-1:0] <= loop_count_three;
            hrdata[mseq_pkg::HI_LO +: CNT_W] <= loop_reload_alt;
          end
          default: hrdata <= '0;
        endcase
    end
    else
      ap_wr <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      start_address_register <= '0;
      loop_reload_one <= '0;
      loop_reload_two <= '0;
      loop_reload_three <= '0;
      launch_en <= 1'b0;
    end
    else if (ap_wr)
      case (ap_addr)
        mseq_pkg::REG_CTRL: launch_en <= hwdata[mseq_pkg::CTRL_LAUNCH_EN];
        mseq_pkg::REG_START: start_address_register <= hwdata[5:0];
        mseq_pkg::REG_RELOAD1: loop_reload_one <= wfield(hwdata);
        mseq_pkg::REG_RELOAD2: loop_reload_two <= wfield(hwdata);
        mseq_pkg::REG_RELOAD3: loop_reload_three <= wfield(hwdata);
        default: launch_en <= launch_en;
      endcase
  end

  // host strobes; a new set wins over a same-cycle clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    logic wc;
    if (!rstn)
    begin
      launch_req <= 1'b0;
      clear_req <= 1'b0;
      irq <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      wc = ap_wr && ap_addr == mseq_pkg::REG_CTRL;
      if (wc && hwdata[mseq_pkg::CTRL_LAUNCH])
        launch_req <= 1'b1;
      else if (step || (ce && clear_go))
        launch_req <= 1'b0;
      if (wc && hwdata[mseq_pkg::CTRL_CLEAR])
        clear_req <= 1'b1;
      else if (ce)
        clear_req <= 1'b0;
      if (wc && hwdata[mseq_pkg::CTRL_IRQ_SET])
        irq <= 1'b1;
      else if ((wc && hwdata[mseq_pkg::CTRL_IRQ_CLR]) || (ce && clear_go))
        irq <= 1'b0;
      if (wc && hwdata[mseq_pkg::CTRL_READY])
        ready <= 1'b1;
      else if (ce && clear_go)
        ready <= 1'b0;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // deeper stack entries hold no value until a first push has landed
  logic stk_primed;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      stk_primed <= 1'b0;
    else if (step && !clear_go && do_push)
      stk_primed <= 1'b1;
  end

  logic plain;
  assign plain = step && !clear_go && !launch_go
    && irq_st != mseq_pkg::IRQ_PUSH && irq_st != mseq_pkg::IRQ_HOLD;

  direct_jump_a: assert property (
    plain && code[3:2] == mseq_pkg::SRC_DA
    |=> pc == $past(direct_jump_field))
    else $error("direct jump address not taken");
  idle_hold_a: assert property (
    plain && pc == mseq_pkg::PC_IDLE && code[3:2] == mseq_pkg::SRC_T
    |=> pc == mseq_pkg::PC_IDLE && tnext == mseq_pkg::PC_IDLE)
    else $error("idle location left without a jump");
  tnext_a: assert property (
    step && !clear_go && next_pc != mseq_pkg::PC_IDLE
    |=> tnext == pc + 6'h01)
    else $error("incremented pc register wrong");
  push_a: assert property (
    plain && do_push |=> return_stack[0] == $past(tnext)
    && (!$past(stk_primed) || return_stack[1] == $past(return_stack[0])))
    else $error("push did not store incremented pc");
  pop_a: assert property (
    step && !clear_go && do_pop |=> return_stack[STACK_D-1]
    == $past(return_stack[0]))
    else $error("pop did not rotate the stack");
  return_a: assert property (
    plain && code[3:2] == mseq_pkg::SRC_RS
    |=> pc == $past(return_stack[0]))
    else $error("return address not taken from stack");
  run_ind_a: assert property (
    run == busy(pc))
    else $error("run indication disagrees with pc");
  clear_all_a: assert property (
    ce && clear_go |=> pc == mseq_pkg::PC_IDLE && !irq && !ready)
    else $error("global clear incomplete");
  alt_load_a: assert property (
    ce && !phase && !clear_go && mw_word[mseq_pkg::ALT_BIT]
    |=> loop_reload_alt == $past(loop_count_one))
    else $error("alternate reload not loaded");
  break_seq_a: assert property (
    step && !clear_go && irq_st == mseq_pkg::IRQ_CONT
    |-> code == mseq_pkg::CODE_CONT
    ##[1:2] step && irq_st == mseq_pkg::IRQ_PUSH && !clear_go
    |=> pc == mseq_pkg::PC_BREAK)
    else $error("break point sequence wrong");
  lc3_dec_a: assert property (
    step && !clear_go && mw_word[mseq_pkg::LC3_LO +: 2]
    == mseq_pkg::LC3_DEC |=> loop_count_three
    == $past(loop_count_three) - 1'b1)
    else $error("counter three did not decrement");
  launch_a: assert property (
    launch_go |=> pc == $past(start_address_register))
    else $error("launch did not load start address");
endmodule : mseq_top

/* File: dv/mseq_ucode_mem.sv */
`timescale 1ns/1ps
// ********************
// microprogram memory model
// ********************
module mseq_ucode_mem (
  input wire logic [5:0] pc,
  output logic [21:0] mw_word,
  output logic [5:0] direct_jump_field
);
  // contents loaded by the bench before launch
  logic [21:0] words [64];
  logic [5:0] jumps [64];
  // combinational read, same clock as pc
  assign mw_word = words[pc];
  assign direct_jump_field = jumps[pc];
endmodule : mseq_ucode_mem

/* File: dv/tb_mseq_top.sv */
`timescale 1ns/1ps
module tb_mseq_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [5:0] pc;
  logic [21:0] mw_word;
  logic [5:0] direct_jump_field;
  logic run;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'h68606f88;
  logic [31:0] rd;
  int mpc;
  int lc1;
  int rl1;
  int stk [$];

  always #25 clk_sys = ~clk_sys;

  mseq_top mseq_top_i (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pc(pc), .mw_word(mw_word),
    .direct_jump_field(direct_jump_field), .run(run)
  );

  mseq_ucode_mem mseq_ucode_mem_i (
    .pc(pc), .mw_word(mw_word), .direct_jump_field(direct_jump_field)
  );

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xorshift

  function automatic logic [21:0] mk(input logic [3:0] a,
    input logic [3:0] b, input logic [5:0] cond, input logic [2:0] op);
    return {5'h00, op, cond, b, a};
  endfunction : mk

  task report_and_stop();
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // single word transfer, held until hready seen high
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d, rd);
  endtask : wr

  task wait_pc(input int p);
    repeat (30)
    begin
      @(posedge clk_sys);
      #1;
      if (pc === p[5:0])
        break;
    end
    chk("pc", pc, p);
  endtask : wait_pc

  // one microcycle of the reference sequencer, then compare
  task step();
    logic [21:0] w;
    logic [3:0] c;
    int np;
    w = mseq_ucode_mem_i.words[mpc];
    c = (w[13:8] == 6'h33 && lc1 == 0) ? w[7:4] : w[3:0];
    case (c[3:2])
      2'h0: np = (mpc == 0) ? 0 : mpc + 1;
      2'h1: np = mseq_ucode_mem_i.jumps[mpc];
      default: np = stk[0];
    endcase
    if (c[1:0] == 2'h1)
    begin
      stk.push_front(mpc + 1);
      if (stk.size() > 4)
        void'(stk.pop_back());
    end
    else if (c[1:0] == 2'h0)
      stk.push_back(stk.pop_front());
    if (w[16:14] == 3'h1)
      lc1 = (lc1 - 1) & 32'hfff;
    else if (w[16:14] == 3'h2)
      lc1 = rl1;
    mpc = np;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pc", pc, mpc);
    chk("run", run, mpc != 0 && mpc != 63);
  endtask : step

  // ********************
  // main sequence
  // ********************
  initial
  begin
    for (int i = 0; i < 64; i++)
    begin
      mseq_ucode_mem_i.words[i] = mk(4'h2, 4'h0, 6'h20, 3'h0);
      mseq_ucode_mem_i.jumps[i] = 6'h00;
    end
    // load, call loop, count down, return, go idle
    // counter three decrements once here
    mseq_ucode_mem_i.words[5] = mk(4'h2, 4'h0, 6'h20, 3'h2) | 22'h080000;
    mseq_ucode_mem_i.words[6] = mk(4'h5, 4'h0, 6'h20, 3'h0);
    mseq_ucode_mem_i.jumps[6] = 6'h10;
    mseq_ucode_mem_i.words[16] = mk(4'h6, 4'h8, 6'h33, 3'h1);
    mseq_ucode_mem_i.jumps[16] = 6'h10;
    // copy of counter one into the alternate reload here
    mseq_ucode_mem_i.words[7] = mk(4'h6, 4'h0, 6'h20, 3'h0) | 22'h200000;
    // self loops for the break point run
    for (int i = 32; i < 64; i = i + 31)
    begin
      mseq_ucode_mem_i.words[i] = mk(4'h6, 4'h0, 6'h20, 3'h0);
      mseq_ucode_mem_i.jumps[i] = i[5:0];
    end
    mseq_ucode_mem_i.words[33] = mk(4'h6, 4'h0, 6'h20, 3'h0);
    mseq_ucode_mem_i.jumps[33] = 6'h20;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    ce <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("pc", pc, 0);
    chk("resp", {hreadyout, hresp}, 2'h2);
    ahb(8'h40, 1'b0, 32'h0, rd);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 3; i++)
    begin
      seed = xorshift(seed);
      wr(8'h08 + 8'(4 * i), seed);
      ahb(8'h08 + 8'(4 * i), 1'b0, 32'h0, rd);
      chk("reload", rd, seed & 32'hfff);
    end
    rl1 = int'(seed[2:0]) + 1;
    wr(mseq_pkg::REG_RELOAD1, rl1);
    wr(mseq_pkg::REG_START, 32'h5);
    ahb(mseq_pkg::REG_START, 1'b0, 32'h0, rd);
    chk("start", rd, 32'h5);
    wr(mseq_pkg::REG_CTRL, 32'h30);
    wr(mseq_pkg::REG_CTRL, 32'h21);
    wait_pc(5);
    mpc = 5;
    lc1 = 0;
    while (mpc != 0)
      step();
    repeat (4) step();
    ahb(mseq_pkg::REG_COUNT12, 1'b0, 32'h0, rd);
    chk("count", rd & 32'hfff, lc1);
    ahb(mseq_pkg::REG_COUNT3, 1'b0, 32'h0, rd);
    chk("count3", rd, (lc1 << 16) | 32'hfff);
    wr(mseq_pkg::REG_START, 32'h20);
    wr(mseq_pkg::REG_CTRL, 32'h30);
    wr(mseq_pkg::REG_CTRL, 32'h21);
    wait_pc(32);
    wr(mseq_pkg::REG_CTRL, 32'h24);
    wait_pc(63);
    chk("run", run, 0);
    ahb(mseq_pkg::REG_STATUS, 1'b0, 32'h0, rd);
    chk("irq", rd[9], 1);
    wr(mseq_pkg::REG_CTRL, 32'h28);
    repeat (20)
    begin
      @(posedge clk_sys);
      #1;
      if (pc !== 6'h3f)
        break;
    end
    chk("resume", pc[5:1], 5'h10);
    wr(mseq_pkg::REG_CTRL, 32'h22);
    wait_pc(0);
    ahb(mseq_pkg::REG_STATUS, 1'b0, 32'h0, rd);
    chk("status", rd[10:8], 0);
    // no ready after clear, so launch must be refused
    wr(mseq_pkg::REG_CTRL, 32'h21);
    repeat (8) @(posedge clk_sys);
    #1;
    chk("pc", pc, 0);
    report_and_stop();
  end

  // ends a hang well after the expected run of under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule : tb_mseq_top
